// ==== logic/tsicm_ctrl.v ====
// FIFO and top level of the connection-memory and data-memory controller.
`timescale 1ns/10ps
`include "tsicm_consts.vh"

module tsicm_fifo #(
    parameter WIDTH = 23,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock_in,
    input wire srst_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0] wr_ptr, rd_ptr;
    reg [AW:0] count;
    wire push, pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != {(AW+1){1'b0}});
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = store[rd_ptr];

    // Storage is written only on a real push.
    always @(posedge clock_in)
    begin
        if (push)
        begin
            store[wr_ptr] <= in_data_in;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module tsicm_ctrl #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4,
    parameter BP_LIMIT_CYC = `TSICM_BP_LIMIT_NS / `TSICM_CLK_NS
) (
    input wire clock_in,
    input wire srst_in,
    input wire frame_start_in,
    input wire rx_valid_in,
    input wire rx_side_in,
    input wire [12:0] rx_index_in,
    input wire [7:0] rx_data_in,
    input wire out_req_valid_in,
    input wire out_req_side_in,
    input wire [12:0] out_req_chan_in,
    output wire out_req_ready_out,
    output wire tx_valid_out,
    input wire tx_ready_in,
    output wire tx_side_out,
    output wire [12:0] tx_chan_out,
    output wire [7:0] tx_data_out,
    output wire tx_hiz_out,
    input wire output_disable_pin_n_in,
    input wire local_out_reset_state_in,
    input wire backplane_out_reset_state_in,
    output reg [3:0] local_buffer_ctl_out,
    output reg [3:0] backplane_buffer_ctl_out,
    input wire [2:0] mem_select_in,
    input wire block_mode_bit_in,
    input wire block_enable_set_in,
    input wire block_enable_clear_in,
    input wire [2:0] local_pattern_bits_in,
    input wire [2:0] backplane_pattern_bits_in,
    output reg block_enable_bit_out,
    input wire host_cs_n_in,
    input wire host_ds_n_in,
    input wire host_rw_in,
    input wire [14:0] host_addr_in,
    input wire [15:0] host_data_in,
    output reg [15:0] host_data_out,
    output wire host_data_oe_out,
    output reg data_transfer_ack_n_out
);
    localparam DM_WORDS = `TSICM_PAGES * `TSICM_CM_WORDS;
    localparam BP_LAST = `TSICM_CM_WORDS - 1;
    localparam FW = 1 + `TSICM_IDX_W + 8 + 1;

    // Connection stores, one word per output channel.
    reg [15:0] local_conn_store [0:`TSICM_CM_WORDS-1];
    reg [15:0] backplane_conn_store [0:`TSICM_CM_WORDS-1];
    // Data memories, four pages each, addressed {page, stream/channel index}.
    reg [7:0] local_data_mem [0:DM_WORDS-1], backplane_data_mem [0:DM_WORDS-1];

    reg [1:0] write_page;
    wire [1:0] read_page;
    reg prog_active, hs_state, host_read, stage_valid, stage_side, stage_force, stage_rst_state, next_tx_hiz;
    reg [12:0] prog_addr, stage_chan;
    reg [14:0] prog_guard;
    reg [15:0] stage_word, next_host_data;
    reg [7:0] next_tx_data;
    wire fifo_in_ready, stage_advance, src_side, host_strobe, host_mem, host_cm_write_ok, disabled;
    wire [14:0] src_addr, host_dm_addr;
    wire [7:0] src_byte;
    wire [FW-1:0] fifo_in, fifo_out;

    assign disabled = !output_disable_pin_n_in;

    // Pages rotate once per frame; reading trails writing by three frames.
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            write_page <= 2'h0;
        end
        else if (frame_start_in)
        begin
            write_page <= write_page + 2'h1;
        end
    end
    assign read_page = write_page + `TSICM_READ_LAG;

    // Received bytes land in the current write page of their input side.
    always @(posedge clock_in)
    begin
        if (rx_valid_in)
        begin
            if (rx_side_in)
            begin
                backplane_data_mem[{write_page, rx_index_in}] <= rx_data_in;
            end
            else
            begin
                local_data_mem[{write_page, rx_index_in}] <= rx_data_in;
            end
        end
    end

    // Block programming engine: one address per clock through both stores.
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            prog_active <= 1'b0;
            prog_addr <= 13'h0000;
            prog_guard <= 15'h0000;
            block_enable_bit_out <= 1'b0;
        end
        else if (!block_mode_bit_in || block_enable_clear_in)
        begin
            prog_active <= 1'b0;
            prog_addr <= 13'h0000;
            prog_guard <= 15'h0000;
            block_enable_bit_out <= 1'b0;
        end
        else if (block_enable_set_in && !block_enable_bit_out)
        begin
            prog_active <= 1'b1;
            prog_addr <= 13'h0000;
            prog_guard <= 15'h0000;
            block_enable_bit_out <= 1'b1;
        end
        else if (prog_active)
        begin
            prog_guard <= prog_guard + 15'h0001;
            if (prog_addr == BP_LAST[`TSICM_IDX_W-1:0] || prog_guard == BP_LIMIT_CYC[14:0])
            begin
                prog_active <= 1'b0;
                block_enable_bit_out <= 1'b0;
            end
            else
            begin
                prog_addr <= prog_addr + 13'h0001;
            end
        end
    end

    // Host port decode; the ack handshake never waits on frame timing.
    assign host_strobe = !host_cs_n_in && !host_ds_n_in && (hs_state == `TSICM_HS_IDLE);
    assign host_mem = host_addr_in[`TSICM_MEM_SPACE_BIT];
    assign host_cm_write_ok = host_strobe && host_mem && !host_rw_in && !prog_active;
    assign host_dm_addr = {read_page, host_addr_in[12:0]};

    // Connection store writes: programming has priority, host writes ignored meanwhile.
    always @(posedge clock_in)
    begin
        if (prog_active)
        begin
            local_conn_store[prog_addr] <= {local_pattern_bits_in, 13'h0000};
            backplane_conn_store[prog_addr] <= {backplane_pattern_bits_in, 13'h0000};
        end
        else if (host_cm_write_ok && mem_select_in == `TSICM_SEL_LOC_CM)
        begin
            local_conn_store[host_addr_in[12:0]] <= host_data_in;
        end
        else if (host_cm_write_ok && mem_select_in == `TSICM_SEL_BP_CM)
        begin
            backplane_conn_store[host_addr_in[12:0]] <= host_data_in;
        end
    end

    // Read data for the host; data memories answer reads, writes to them do nothing.
    always @*
    begin
        next_host_data = 16'h0000;
        if (host_mem)
        begin
            case (mem_select_in)
                `TSICM_SEL_LOC_CM: next_host_data = local_conn_store[host_addr_in[12:0]];
                `TSICM_SEL_BP_CM: next_host_data = backplane_conn_store[host_addr_in[12:0]];
                `TSICM_SEL_LOC_DM: next_host_data = {8'h00, local_data_mem[host_dm_addr]};
                `TSICM_SEL_BP_DM: next_host_data = {8'h00, backplane_data_mem[host_dm_addr]};
                default: next_host_data = 16'h0000;
            endcase
        end
    end

    // Handshake: ack low the cycle after a strobe, held until select or strobe rises.
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            hs_state <= `TSICM_HS_IDLE;
            data_transfer_ack_n_out <= 1'b1;
            host_read <= 1'b0;
            host_data_out <= 16'h0000;
        end
        else
        begin
            case (hs_state)
                `TSICM_HS_IDLE:
                begin
                    if (host_strobe)
                    begin
                        hs_state <= `TSICM_HS_ACK;
                        data_transfer_ack_n_out <= 1'b0;
                        host_read <= host_rw_in;
                        host_data_out <= host_rw_in ? next_host_data : 16'h0000;
                    end
                end
                `TSICM_HS_ACK:
                begin
                    if (host_cs_n_in || host_ds_n_in)
                    begin
                        hs_state <= `TSICM_HS_IDLE;
                        data_transfer_ack_n_out <= 1'b1;
                        host_read <= 1'b0;
                    end
                end
                default:
                begin
                    hs_state <= `TSICM_HS_IDLE;
                    data_transfer_ack_n_out <= 1'b1;
                    host_read <= 1'b0;
                end
            endcase
        end
    end
    assign host_data_oe_out = host_read && !data_transfer_ack_n_out && !host_cs_n_in;

    // Output requests: stage one fetches the connection word of the channel.
    assign stage_advance = !stage_valid || fifo_in_ready;
    assign out_req_ready_out = stage_advance;
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            stage_valid <= 1'b0;
            stage_side <= 1'b0;
            stage_chan <= 13'h0000;
            stage_word <= 16'h0000;
            stage_force <= 1'b0;
            stage_rst_state <= 1'b0;
        end
        else if (stage_advance)
        begin
            stage_valid <= out_req_valid_in;
            stage_side <= out_req_side_in;
            stage_chan <= out_req_chan_in;
            stage_word <= out_req_side_in ? backplane_conn_store[out_req_chan_in]
                : local_conn_store[out_req_chan_in];
            stage_force <= disabled;
            stage_rst_state <= out_req_side_in ? backplane_out_reset_state_in : local_out_reset_state_in;
        end
    end

    // Bit 15 low takes the other side as source; index is stream and channel packed.
    assign src_side = stage_word[`TSICM_SRC_BIT] ? stage_side : !stage_side;
    assign src_addr = {read_page, stage_word[`TSICM_IDX_HI:0]};
    assign src_byte = src_side ? backplane_data_mem[src_addr] : local_data_mem[src_addr];

    // Stage two picks message byte or switched byte and applies idle forcing.
    always @*
    begin
        next_tx_data = src_byte;
        next_tx_hiz = 1'b0;
        if (stage_word[`TSICM_MSG_BIT])
        begin
            next_tx_data = stage_word[`TSICM_MSG_HI:0];
        end
        if (!stage_word[`TSICM_OE_BIT] || stage_force)
        begin
            next_tx_data = `TSICM_IDLE_BYTE;
            next_tx_hiz = stage_rst_state;
        end
    end

    assign fifo_in = {stage_side, stage_chan, next_tx_data, next_tx_hiz};

    // Sixteen-entry buffer between the switch core and the serial outputs.
    tsicm_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_out_fifo (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .in_valid_in(stage_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in),
        .out_data_out(fifo_out)
    );

    assign tx_side_out = fifo_out[FW-1];
    assign tx_chan_out = fifo_out[FW-2:9];
    assign tx_data_out = fifo_out[8:1];
    assign tx_hiz_out = fifo_out[0];

    // External buffer controls are held low while outputs are disabled.
    always @(posedge clock_in)
    begin
        if (srst_in || disabled)
        begin
            local_buffer_ctl_out <= `TSICM_BUF_OFF;
            backplane_buffer_ctl_out <= `TSICM_BUF_OFF;
        end
        else
        begin
            local_buffer_ctl_out <= `TSICM_BUF_ON;
            backplane_buffer_ctl_out <= `TSICM_BUF_ON;
        end
    end
endmodule

// ==== logic/tsicm_consts.vh ====
// Shared constants for the time-slot interchange connection-memory controller.
`ifndef TSICM_CONSTS_VH
`define TSICM_CONSTS_VH

// Connection-store and data-memory geometry.
`define TSICM_CM_WORDS 8192
`define TSICM_IDX_W 13
`define TSICM_CM_W 16
`define TSICM_PAGES 4
`define TSICM_PAGE_W 2
// Read page sits one ahead of the write page, which puts it three frames behind the write page.
`define TSICM_READ_LAG 2'h1

// Connection word fields.
`define TSICM_SRC_BIT 15
`define TSICM_MSG_BIT 14
`define TSICM_OE_BIT 13
`define TSICM_PAT_HI 15
`define TSICM_PAT_LO 13
`define TSICM_IDX_HI 12
`define TSICM_MSG_HI 7

// Memory-select codes seen by the host port.
`define TSICM_SEL_LOC_CM 3'h0
`define TSICM_SEL_BP_CM 3'h1
`define TSICM_SEL_LOC_DM 3'h2
`define TSICM_SEL_BP_DM 3'h3

// Host address bit that opens the memory space.
`define TSICM_MEM_SPACE_BIT 14

// Idle byte and forced levels.
`define TSICM_IDLE_BYTE 8'hff
`define TSICM_BUF_ON 4'hf
`define TSICM_BUF_OFF 4'h0

// Block programming must finish within this time; clock period in ns.
`define TSICM_BP_LIMIT_NS 125000
`define TSICM_CLK_NS 5

// Host handshake states.
`define TSICM_HS_IDLE 1'b0
`define TSICM_HS_ACK 1'b1

`endif

// ==== sim/tsicm_ctrl_asserts.sv ====
// Port-level checks for the connection-memory controller.
`timescale 1ns/10ps
module tsicm_chk (
    input wire clock_in,
    input wire srst_in,
    input wire host_cs_n_in,
    input wire host_ds_n_in,
    input wire host_rw_in,
    input wire host_data_oe_out,
    input wire data_transfer_ack_n_out,
    input wire block_mode_bit_in,
    input wire block_enable_set_in,
    input wire block_enable_clear_in,
    input wire block_enable_bit_out,
    input wire output_disable_pin_n_in,
    input wire [3:0] local_buffer_ctl_out,
    input wire [3:0] backplane_buffer_ctl_out,
    input wire tx_valid_out,
    input wire tx_ready_in,
    input wire [7:0] tx_data_out
);
default clocking dc @(posedge clock_in);
endclocking
default disable iff (srst_in);
reg [13:0] bp_cnt;
// Counts the cycles of the current programming pass.
always @(posedge clock_in)
begin
    if (srst_in || !block_enable_bit_out)
        bp_cnt <= 14'h0;
    else
        bp_cnt <= bp_cnt + 14'h1;
end
a_ack_answer:
    assert property (!host_cs_n_in && !host_ds_n_in && data_transfer_ack_n_out && $past(host_ds_n_in)
        |=> !data_transfer_ack_n_out) else $error("access not acknowledged");
a_ack_hold:
    assert property (!data_transfer_ack_n_out && !host_cs_n_in && !host_ds_n_in
        |=> !data_transfer_ack_n_out) else $error("acknowledge dropped early");
a_ack_drop:
    assert property (!data_transfer_ack_n_out && (host_cs_n_in || host_ds_n_in)
        |=> data_transfer_ack_n_out) else $error("acknowledge not released");
a_oe_read:
    assert property (host_data_oe_out |-> host_rw_in && !host_cs_n_in && !data_transfer_ack_n_out)
        else $error("data bus driven outside a read");
a_oe_drive:
    assert property ($fell(data_transfer_ack_n_out) && host_rw_in && !host_cs_n_in |-> host_data_oe_out)
        else $error("read data not driven");
a_bp_start:
    assert property (block_mode_bit_in && block_enable_set_in && !block_enable_clear_in && !block_enable_bit_out
        |=> block_enable_bit_out) else $error("programming did not start");
a_bp_abort:
    assert property (block_enable_clear_in |=> !block_enable_bit_out) else $error("clear did not abort");
a_bp_mode:
    assert property (!block_mode_bit_in |=> !block_enable_bit_out) else $error("enable high without mode");
a_bp_bound:
    assert property (block_enable_bit_out |-> bp_cnt < 14'h2000) else $error("programming pass too long");
a_buf_off:
    assert property (!output_disable_pin_n_in |=> local_buffer_ctl_out == 4'h0 && backplane_buffer_ctl_out == 4'h0)
        else $error("buffer controls not low");
a_buf_on:
    assert property (output_disable_pin_n_in |=> local_buffer_ctl_out == 4'hf && backplane_buffer_ctl_out == 4'hf)
        else $error("buffer controls not high");
a_tx_hold:
    assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
        else $error("output entry lost while stalled");
endmodule
bind tsicm_ctrl tsicm_chk tsicm_chk_i (.clock_in, .srst_in, .host_cs_n_in, .host_ds_n_in, .host_rw_in,
    .host_data_oe_out, .data_transfer_ack_n_out, .block_mode_bit_in, .block_enable_set_in,
    .block_enable_clear_in, .block_enable_bit_out, .output_disable_pin_n_in, .local_buffer_ctl_out,
    .backplane_buffer_ctl_out, .tx_valid_out, .tx_ready_in, .tx_data_out);

// ==== sim/tsicm_host.sv ====
// Host processor model driving the parallel port one access at a time.
`timescale 1ns/10ps
module tsicm_host (
    input wire clock_in,
    input wire data_transfer_ack_n_out,
    input wire [15:0] host_data_out,
    output reg host_cs_n_in,
    output reg host_ds_n_in,
    output reg host_rw_in,
    output reg [14:0] host_addr_in,
    output reg [15:0] host_data_in
);
// Bus starts idle with select and strobe high.
initial
begin
    host_cs_n_in = 1;
    host_ds_n_in = 1;
    host_rw_in = 1;
    host_addr_in = 0;
    host_data_in = 0;
end
// Holds a request until acknowledge, releases it, then keeps the gap.
task acc(input rw, input [14:0] a, input [15:0] d, output [15:0] q);
integer n;
begin
    host_rw_in = rw;
    host_addr_in = a;
    host_data_in = d;
    host_cs_n_in = 0;
    host_ds_n_in = 0;
    n = 0;
    @(posedge clock_in);
    while (data_transfer_ack_n_out !== 1'b0)
    begin
        n = n + 1;
        if (n > 20)
            tb.timeout_hit;
        @(posedge clock_in);
    end
    q = host_data_out;
    @(negedge clock_in);
    host_cs_n_in = 1;
    host_ds_n_in = 1;
    host_data_in = ~d; // Released lines do not keep the old value.
    @(posedge clock_in);
    while (data_transfer_ack_n_out !== 1'b1)
    begin
        n = n + 1;
        if (n > 40)
            tb.timeout_hit;
        @(posedge clock_in);
    end
    repeat (7) @(negedge clock_in);
end
endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the connection-memory controller.
`timescale 1ns/10ps
module tb;
reg clock_in = 0;
reg srst_in = 1;
reg fs = 0, rxv = 0, rxs = 0, rqv = 0, rqs = 0, txr = 0, ode_n = 0, lrs = 0, brs = 1;
reg mode = 0, bset = 0, bclr = 0;
reg [12:0] rxi = 0, rqc = 0;
reg [7:0] rxd = 0;
reg [2:0] msel = 0, lpat = 0, bpat = 0;
wire cs_n, ds_n, rw, rqr, txv, txs, txh, oe, ack_n, block_enable_bit;
wire [14:0] addr;
wire [15:0] hdi, hdo;
wire [12:0] txc;
wire [7:0] txd;
wire [3:0] lbuf, bbuf;
reg [15:0] cm [0:1][0:8191];
reg [7:0] dm [0:1][0:3][0:8191];
reg [22:0] q [$];
reg [15:0] r, w;
integer error_cnt = 0, checks = 0, wp = 0, i, n, ref_n = 0;
tsicm_ctrl tsicm_ctrl_i (.clock_in, .srst_in, .frame_start_in(fs), .rx_valid_in(rxv), .rx_side_in(rxs),
    .rx_index_in(rxi), .rx_data_in(rxd), .out_req_valid_in(rqv), .out_req_side_in(rqs), .out_req_chan_in(rqc),
    .out_req_ready_out(rqr), .tx_valid_out(txv), .tx_ready_in(txr), .tx_side_out(txs), .tx_chan_out(txc),
    .tx_data_out(txd), .tx_hiz_out(txh), .output_disable_pin_n_in(ode_n), .local_out_reset_state_in(lrs),
    .backplane_out_reset_state_in(brs), .local_buffer_ctl_out(lbuf), .backplane_buffer_ctl_out(bbuf),
    .mem_select_in(msel), .block_mode_bit_in(mode), .block_enable_set_in(bset), .block_enable_clear_in(bclr),
    .local_pattern_bits_in(lpat), .backplane_pattern_bits_in(bpat), .block_enable_bit_out(block_enable_bit),
    .host_cs_n_in(cs_n), .host_ds_n_in(ds_n), .host_rw_in(rw), .host_addr_in(addr), .host_data_in(hdi),
    .host_data_out(hdo), .host_data_oe_out(oe), .data_transfer_ack_n_out(ack_n));
tsicm_host tsicm_host_i (.clock_in, .data_transfer_ack_n_out(ack_n), .host_data_out(hdo), .host_cs_n_in(cs_n),
    .host_ds_n_in(ds_n), .host_rw_in(rw), .host_addr_in(addr), .host_data_in(hdi));
// Free-running 200 MHz clock.
initial forever #2.5 clock_in = ~clock_in;
// Compares one value and counts the outcome.
task chk(input [31:0] g, input [31:0] e);
begin
    checks = checks + 1;
    if (g !== e)
    begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
end
endtask
// Prints the verdict and ends the run.
task final_report;
begin
    if (error_cnt == 0 && checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
// Ends the run after a wait that ran out.
task timeout_hit;
begin
    error_cnt = error_cnt + 1;
    $display("unexpected at %0t: wait ran out", $time);
    final_report;
end
endtask
// Host write and checked host read with a memory select.
task wr(input [2:0] s, input [14:0] a, input [15:0] d);
begin
    msel = s;
    tsicm_host_i.acc(0, a, d, r);
end
endtask
task rd(input [2:0] s, input [14:0] a, input [15:0] e);
begin
    msel = s;
    tsicm_host_i.acc(1, a, 0, r);
    chk(r, e);
end
endtask
// Runs a programming pass; a nonzero ab aborts it by clear or by mode.
task bp(input [2:0] lp, input [2:0] bq, input integer ab, input km);
integer k;
begin
    lpat = lp;
    bpat = bq;
    mode = 1;
    @(negedge clock_in);
    bset = 1;
    @(negedge clock_in);
    bset = 0;
    n = 0;
    while (block_enable_bit === 1'b1 && n < 25000)
    begin
        n = n + 1;
        if (n == ab)
        begin
            bclr = !km;
            mode = !km;
        end
        @(negedge clock_in);
        bclr = 0;
    end
    if (n >= 25000)
        timeout_hit;
    chk(n, ab ? ab : 8192);
    for (k = 0; k < n && ab == 0; k = k + 1)
    begin
        cm[0][k] = {lp, 13'h0};
        cm[1][k] = {bq, 13'h0};
    end
end
endtask
// Starts a frame and fills indexes 0 to 255 of both sides.
task frame;
integer k;
begin
    fs = 1;
    @(negedge clock_in);
    fs = 0;
    wp = (wp + 1) % 4;
    for (k = 0; k < 512; k = k + 1)
    begin
        rxv = 1;
        rxs = k % 2;
        rxi = k / 2;
        rxd = $urandom;
        dm[rxs][wp][rxi] = rxd;
        @(negedge clock_in);
    end
    rxv = 0;
end
endtask
// Expected output entry for a request taken now.
function [22:0] expv(input s, input [12:0] c, input od);
reg [15:0] x;
reg src;
begin
    x = cm[s][c];
    src = x[15] ? s : !s;
    if (!x[13] || !od)
        expv = {s, c, 8'hff, s ? brs : lrs};
    else if (x[14])
        expv = {s, c, x[7:0], 1'b0};
    else
        expv = {s, c, dm[src][(wp + 1) % 4][x[12:0]], 1'b0};
end
endfunction
// Main sequence.
initial
begin
    r = $urandom(8);
    repeat (12) @(negedge clock_in);
    srst_in = 0;
    chk({lbuf, bbuf, block_enable_bit}, 0);
    fork
        bp($urandom, $urandom, 0, 0);
        begin
            repeat (100) @(negedge clock_in);
            wr(0, 15'h400a, 16'h1234);
        end
    join
    rd(0, 15'h400a, cm[0][10]);
    rd(1, 15'h5fff, cm[1][8191]);
    bp(3'h5, 3'h2, 300, 0);
    rd(0, 15'h4000, 16'ha000);
    rd(1, 15'h5fff, cm[1][8191]);
    bp(3'h0, 3'h0, 40, 1);
    bp(3'h0, 3'h0, 0, 0);
    ode_n = 1;
    @(negedge clock_in);
    chk({lbuf, bbuf}, 8'hff);
    for (i = 0; i < 16; i = i + 1)
    begin
        r = $urandom;
        w = {r[15:13], 5'h0, r[7:0]};
        cm[i % 2][i / 2] = w;
        wr(i % 2, 15'h4000 + i / 2, w);
    end
    wr(0, 15'h0003, 16'hffff);
    rd(0, 15'h0003, 16'h0);
    rd(0, 15'h4003, cm[0][3]);
    repeat (4) frame;
    wr(2, 15'h4005, 16'h00aa);
    rd(2, 15'h4005, dm[0][(wp + 1) % 4][5]);
    rd(3, 15'h4009, dm[1][(wp + 1) % 4][9]);
    for (i = 0; i < 200; i = i + 1)
    begin
        rqv = i < 60;
        rqs = $urandom % 2;
        rqc = $urandom % 9;
        if (rqc == 8)
            rqc = 300;
        ode_n = $urandom % 4 != 0;
        txr = i > 30 && $urandom % 2;
        #1;
        if (rqv && rqr)
            q.push_back(expv(rqs, rqc, ode_n));
        else if (rqv)
            ref_n = ref_n + 1;
        if (txv === 1'b1 && txr)
        begin
            if (q.size() == 0)
                chk(0, 1);
            else
                chk({txs, txc, txd, txh}, q.pop_front());
        end
        @(negedge clock_in);
    end
    chk(ref_n > 0, 1);
    chk(txv, 0);
    chk(q.size(), 0);
    final_report;
end
endmodule
